// ==== hdl/ccp_pkg.sv ====
// shared constants, types and register map of the card parameter checker
package ccp_pkg;
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CCP_SYSCODE_OFS  = 8'h00;
  localparam logic [7:0] CCP_ID_LO_OFS    = 8'h04;
  localparam logic [7:0] CCP_ID_HI_OFS    = 8'h08;
  localparam logic [7:0] CCP_TIMING_OFS   = 8'h0C;
  localparam logic [7:0] CCP_CMDSTAT_OFS  = 8'h10;
  localparam logic [7:0] CCP_IRQ_STAT_OFS = 8'h14;
  localparam logic [7:0] CCP_IRQ_MASK_OFS = 8'h18;
  localparam logic [7:0] CCP_WAIT_OFS     = 8'h1C;
  // ----------------------------------------------------------------
  // reset values and fixed codes
  // ----------------------------------------------------------------
  localparam logic [15:0] CCP_SYSCODE_RST = 16'h0000;
  localparam logic [15:0] CCP_TIMING_RST  = 16'h0000;
  localparam logic [15:0] CCP_SC_WILD     = 16'hFFFF;
  localparam logic [15:0] CCP_SC_GROUP    = 16'hAAFF;
  localparam logic [7:0]  CCP_SC_HI_GROUP = 8'hAA;
  localparam logic [7:0]  CCP_DESC_FF     = 8'hFF;
  localparam logic [7:0]  CCP_DESC_00     = 8'h00;
  localparam logic [2:0]  CCP_MODE_RSVD   = 3'h5;
  localparam logic [7:0]  CCP_SLOT_FIRST  = 8'h00;
  localparam int          CCP_BLOCK_BYTES = 16;
  // interrupt status bit positions
  localparam int CCP_IRQ_POLL = 0;
  localparam int CCP_IRQ_OK   = 1;
  localparam int CCP_IRQ_ERR  = 2;
  localparam int CCP_IRQ_N    = 3;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {CCP_K_START, CCP_K_SERVICE, CCP_K_ELEMENT, CCP_K_FINISH} ccp_kind_t;
  typedef enum {CCP_S_IDLE, CCP_S_COLLECT} ccp_state_t;
  // polling request from the frame layer
  typedef struct packed {
    logic        valid;
    logic [15:0] sys_code;
    logic [7:0]  slots;
  } ccp_poll_req_t;
  // polling answer to the frame layer
  typedef struct packed {
    logic        valid;
    logic [7:0]  slot;
    logic [63:0] card_id;
    logic [63:0] time_desc;
  } ccp_poll_rsp_t;
  // one item of a read or write command: data holds d0,d1,d2 or a service
  typedef struct packed {
    logic        valid;
    ccp_kind_t   kind;
    logic        is_write;
    logic        three_byte;
    logic [23:0] data;
  } ccp_cmd_item_t;
  // verdict of a finished command
  typedef struct packed {
    logic        done;
    logic        error;
    logic        mem_go;
    logic [7:0]  blocks;
    logic [2:0]  mode;
    logic [19:0] wait_t;
  } ccp_verdict_t;
endpackage

// ==== hdl/ccp_param_checker.sv ====
// polling answer, service list and block element checks with axi4-lite registers
`timescale 1ns/100ps
`default_nettype none
// Contract
// - code FFFF always gets a poll answer
// - code AAFF answers when stored upper byte AA
// - other codes answer only on exact match
// - poll answer carries eight byte card identifier
// - descriptor bytes 0,1,7 FF; bytes 2-4 00
// - descriptor bytes 5,6 are read/write timing
// - timing byte splits into E, B, A
// - wait equals ((B+1)n+(A+1)) times 4^E, T units
// - poll answer always in first slot
// - differing service entries give an error
// - data organised as sixteen byte numbered blocks
// - nonzero access mode bits give an error
// - two byte element: bit7 set, second byte block
// - three byte element: block, zeros, mode bits
// - mode 101 is reserved and errors
// - nonzero upper third byte bits give an error
module ccp_param_checker (
  // clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  // axi4-lite slave
  input  wire logic [7:0]             s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [7:0]             s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  // frame layer side
  input  wire ccp_pkg::ccp_poll_req_t poll_req,
  output ccp_pkg::ccp_poll_rsp_t      poll_rsp,
  input  wire ccp_pkg::ccp_cmd_item_t cmd_item,
  output ccp_pkg::ccp_verdict_t       verdict,
  // interrupt
  output logic                        irq
);
  import ccp_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // system code acceptance
  function automatic logic sc_match(input logic [15:0] req, input logic [15:0] stored);
    logic hit;
    hit = 1'b0;
    if (req == CCP_SC_WILD) begin
      hit = 1'b1;
    end else if (req == CCP_SC_GROUP) begin
      hit = (stored[15:8] == CCP_SC_HI_GROUP);
    end else begin
      hit = (req == stored);
    end
    return hit;
  endfunction

  // apply byte strobes to a register word
  function automatic logic [31:0] strobe(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // register and bus state
  // ----------------------------------------------------------------
  logic [15:0]          syscode_q, syscode_d;
  logic [63:0]          card_id_q, card_id_d;
  logic [15:0]          timing_q, timing_d;
  logic [CCP_IRQ_N-1:0] irq_stat_q, irq_stat_d;
  logic [CCP_IRQ_N-1:0] irq_mask_q, irq_mask_d;
  logic                 bvalid_q, bvalid_d;
  logic [1:0]           bresp_q, bresp_d;
  logic                 rvalid_q, rvalid_d;
  logic [1:0]           rresp_q, rresp_d;
  logic [31:0]          rdata_q, rdata_d;
  logic                 wr_take, rd_take;
  logic [CCP_IRQ_N-1:0] irq_evt;

  // both write channels are taken together; one write in flight at most
  assign wr_take       = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
  assign rd_take       = s_axi_arvalid && !rvalid_q;
  assign s_axi_awready = wr_take;
  assign s_axi_wready  = wr_take;
  assign s_axi_arready = rd_take;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;
  assign irq           = |(irq_stat_q & irq_mask_q);

  // ----------------------------------------------------------------
  // command checker state
  // ----------------------------------------------------------------
  ccp_state_t   st_q, st_d;
  logic         err_q, err_d;
  logic         write_q, write_d;
  logic         svc_seen_q, svc_seen_d;
  logic [15:0]  svc_q, svc_d;
  logic [7:0]   nblk_q, nblk_d;
  logic [2:0]   mode_q, mode_d;
  logic [7:0]   last_blk_q, last_blk_d;
  ccp_verdict_t verdict_q, verdict_d;
  ccp_poll_rsp_t poll_q, poll_d;
  logic         elem_bad;
  logic [2:0]   elem_mode;
  logic [7:0]   tparam;
  logic [19:0]  wait_calc;

  // ----------------------------------------------------------------
  // register file next state
  // ----------------------------------------------------------------
  // a decode error answers slverr so software sees a mistyped offset
  always_comb begin
    syscode_d  = syscode_q;
    card_id_d  = card_id_q;
    timing_d   = timing_q;
    irq_mask_d = irq_mask_q;
    irq_stat_d = irq_stat_q;
    bvalid_d   = bvalid_q && !s_axi_bready;
    bresp_d    = bresp_q;
    rvalid_d   = rvalid_q && !s_axi_rready;
    rresp_d    = rresp_q;
    rdata_d    = rdata_q;
    if (wr_take) begin
      bvalid_d = 1'b1;
      bresp_d  = 2'b00;
      if (s_axi_awaddr == CCP_SYSCODE_OFS) begin
        syscode_d = 16'(strobe({16'h0000, syscode_q}, s_axi_wdata, s_axi_wstrb));
      end else if (s_axi_awaddr == CCP_ID_LO_OFS) begin
        card_id_d[31:0] = strobe(card_id_q[31:0], s_axi_wdata, s_axi_wstrb);
      end else if (s_axi_awaddr == CCP_ID_HI_OFS) begin
        card_id_d[63:32] = strobe(card_id_q[63:32], s_axi_wdata, s_axi_wstrb);
      end else if (s_axi_awaddr == CCP_TIMING_OFS) begin
        timing_d = 16'(strobe({16'h0000, timing_q}, s_axi_wdata, s_axi_wstrb));
      end else if (s_axi_awaddr == CCP_IRQ_STAT_OFS) begin
        if (s_axi_wstrb[0]) begin
          irq_stat_d = irq_stat_q & ~s_axi_wdata[CCP_IRQ_N-1:0];
        end
      end else if (s_axi_awaddr == CCP_IRQ_MASK_OFS) begin
        if (s_axi_wstrb[0]) begin
          irq_mask_d = s_axi_wdata[CCP_IRQ_N-1:0];
        end
      end else if (s_axi_awaddr == CCP_CMDSTAT_OFS || s_axi_awaddr == CCP_WAIT_OFS) begin
        bresp_d = 2'b00; // read-only, write ignored
      end else begin
        bresp_d = 2'b10;
      end
    end
    // new events win over a clear in the same cycle
    irq_stat_d = irq_stat_d | irq_evt;
    if (rd_take) begin
      rvalid_d = 1'b1;
      rresp_d  = 2'b00;
      if (s_axi_araddr == CCP_SYSCODE_OFS) begin
        rdata_d = {16'h0000, syscode_q};
      end else if (s_axi_araddr == CCP_ID_LO_OFS) begin
        rdata_d = card_id_q[31:0];
      end else if (s_axi_araddr == CCP_ID_HI_OFS) begin
        rdata_d = card_id_q[63:32];
      end else if (s_axi_araddr == CCP_TIMING_OFS) begin
        rdata_d = {16'h0000, timing_q};
      end else if (s_axi_araddr == CCP_CMDSTAT_OFS) begin
        rdata_d = {8'h00, last_blk_q, nblk_q, 3'h0, mode_q, st_q == CCP_S_COLLECT, err_q};
      end else if (s_axi_araddr == CCP_IRQ_STAT_OFS) begin
        rdata_d = {29'h0, irq_stat_q};
      end else if (s_axi_araddr == CCP_IRQ_MASK_OFS) begin
        rdata_d = {29'h0, irq_mask_q};
      end else if (s_axi_araddr == CCP_WAIT_OFS) begin
        rdata_d = {12'h000, verdict_q.wait_t};
      end else begin
        rdata_d = 32'h0000_0000;
        rresp_d = 2'b10;
      end
    end
  end

  // register file flops
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      syscode_q  <= CCP_SYSCODE_RST;
      card_id_q  <= 64'h0000_0000_0000_0000;
      timing_q   <= CCP_TIMING_RST;
      irq_stat_q <= '0;
      irq_mask_q <= '0;
      bvalid_q   <= 1'b0;
      bresp_q    <= 2'b00;
      rvalid_q   <= 1'b0;
      rresp_q    <= 2'b00;
      rdata_q    <= 32'h0000_0000;
    end else begin
      syscode_q  <= syscode_d;
      card_id_q  <= card_id_d;
      timing_q   <= timing_d;
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
      bvalid_q   <= bvalid_d;
      bresp_q    <= bresp_d;
      rvalid_q   <= rvalid_d;
      rresp_q    <= rresp_d;
      rdata_q    <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // polling answer
  // ----------------------------------------------------------------
  // silence on a miss: valid stays low, the frame layer sends nothing
  always_comb begin
    poll_d       = poll_q;
    poll_d.valid = 1'b0;
    if (poll_req.valid && sc_match(poll_req.sys_code, syscode_q)) begin
      poll_d.valid     = 1'b1;
      poll_d.slot      = CCP_SLOT_FIRST;
      poll_d.card_id   = card_id_q;
      poll_d.time_desc = {CCP_DESC_FF, CCP_DESC_FF, CCP_DESC_00, CCP_DESC_00, CCP_DESC_00,
                          timing_q[7:0], timing_q[15:8], CCP_DESC_FF};
    end
  end

  // ----------------------------------------------------------------
  // block element decode
  // ----------------------------------------------------------------
  // d0 = data[23:16], d1 = block number, d2 = data[7:0]
  always_comb begin
    elem_bad  = (cmd_item.data[22:20] != 3'h0);
    elem_mode = 3'h0;
    if (cmd_item.data[23]) begin
      elem_mode = 3'h0;
      elem_bad  = elem_bad || cmd_item.three_byte;
    end else begin
      elem_mode = cmd_item.data[2:0];
      elem_bad  = elem_bad || !cmd_item.three_byte;
      elem_bad  = elem_bad || (cmd_item.data[7:3] != 5'h00);
      elem_bad  = elem_bad || (cmd_item.data[2:0] == CCP_MODE_RSVD);
    end
  end

  // wait in units of 256*16 carrier periods for the finished command
  always_comb begin
    tparam    = write_q ? timing_q[15:8] : timing_q[7:0];
    wait_calc = 20'((({17'h0, tparam[5:3]} + 20'd1) * {12'h000, nblk_q}
                     + {17'h0, tparam[2:0]} + 20'd1) << {tparam[7:6], 1'b0});
  end

  // ----------------------------------------------------------------
  // command sequencer
  // ----------------------------------------------------------------
  // memory is released only at finish with a clean verdict
  always_comb begin
    st_d        = st_q;
    err_d       = err_q;
    write_d     = write_q;
    svc_seen_d  = svc_seen_q;
    svc_d       = svc_q;
    nblk_d      = nblk_q;
    mode_d      = mode_q;
    last_blk_d  = last_blk_q;
    verdict_d   = verdict_q;
    verdict_d.done   = 1'b0;
    verdict_d.mem_go = 1'b0;
    irq_evt     = '0;
    irq_evt[CCP_IRQ_POLL] = poll_q.valid;
    if (cmd_item.valid) begin
      case (st_q)
        CCP_S_IDLE: begin
          if (cmd_item.kind == CCP_K_START) begin
            st_d       = CCP_S_COLLECT;
            err_d      = 1'b0;
            write_d    = cmd_item.is_write;
            svc_seen_d = 1'b0;
            nblk_d     = 8'h00;
            mode_d     = 3'h0;
          end
        end
        CCP_S_COLLECT: begin
          if (cmd_item.kind == CCP_K_START) begin
            err_d      = 1'b0; // a fresh start drops the half-built command except its mode and last block, which mode_q and last_blk_q keep
            write_d    = cmd_item.is_write;
            svc_seen_d = 1'b0;
            nblk_d     = 8'h00;
          end else if (cmd_item.kind == CCP_K_SERVICE) begin
            svc_seen_d = 1'b1;
            svc_d      = cmd_item.data[15:0];
            if (svc_seen_q && cmd_item.data[15:0] != svc_q) begin
              err_d = 1'b1;
            end
          end else if (cmd_item.kind == CCP_K_ELEMENT) begin
            nblk_d     = nblk_q + 8'h01;
            last_blk_d = cmd_item.data[15:8];
            mode_d     = elem_mode;
            err_d      = err_q || elem_bad;
          end else begin
            st_d             = CCP_S_IDLE;
            verdict_d.done   = 1'b1;
            verdict_d.error  = err_q;
            verdict_d.mem_go = !err_q;
            verdict_d.blocks = nblk_q;
            verdict_d.mode   = mode_q;
            verdict_d.wait_t = wait_calc;
            irq_evt[CCP_IRQ_OK]  = !err_q;
            irq_evt[CCP_IRQ_ERR] = err_q;
          end
        end
        default: st_d = CCP_S_IDLE;
      endcase
    end
  end

  // sequencer and answer flops
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_q       <= CCP_S_IDLE;
      err_q      <= 1'b0;
      write_q    <= 1'b0;
      svc_seen_q <= 1'b0;
      svc_q      <= 16'h0000;
      nblk_q     <= 8'h00;
      mode_q     <= 3'h0;
      last_blk_q <= 8'h00;
      verdict_q  <= '0;
      poll_q     <= '0;
    end else begin
      st_q       <= st_d;
      err_q      <= err_d;
      write_q    <= write_d;
      svc_seen_q <= svc_seen_d;
      svc_q      <= svc_d;
      nblk_q     <= nblk_d;
      mode_q     <= mode_d;
      last_blk_q <= last_blk_d;
      verdict_q  <= verdict_d;
      poll_q     <= poll_d;
    end
  end

  assign poll_rsp = poll_q;
  assign verdict  = verdict_q;
endmodule
`default_nettype wire

// ==== verif/ccp_param_checker_assertions.sv ====
// port-level assertions for the card parameter checker
`timescale 1ns/100ps
`default_nettype none
module ccp_param_checker_assertions (
  // clock and reset
  input wire logic                   core_clk,
  input wire logic                   rst,
  // axi handshakes
  input wire logic                   s_axi_awvalid,
  input wire logic                   s_axi_wvalid,
  input wire logic                   s_axi_awready,
  input wire logic                   s_axi_bvalid,
  // frame layer
  input wire ccp_pkg::ccp_poll_req_t poll_req,
  input wire ccp_pkg::ccp_poll_rsp_t poll_rsp,
  input wire ccp_pkg::ccp_cmd_item_t cmd_item,
  input wire ccp_pkg::ccp_verdict_t  verdict
);
  import ccp_pkg::*;
  logic bad_q;
  logic bad_d;
  logic elem_bad;
  // shadow of element faults; services are left to the bench
  assign elem_bad = cmd_item.data[22:20] != 3'h0 || cmd_item.data[23] == cmd_item.three_byte
    || (cmd_item.three_byte && (cmd_item.data[7:3] != 5'h00
    || cmd_item.data[2:0] == CCP_MODE_RSVD));
  // cleared by start, set by any faulty element
  always_comb begin
    bad_d = bad_q;
    if (cmd_item.valid && cmd_item.kind == CCP_K_START) bad_d = 1'b0;
    if (cmd_item.valid && cmd_item.kind == CCP_K_ELEMENT && elem_bad) bad_d = 1'b1;
  end
  // registered shadow
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) bad_q <= 1'b0;
    else bad_q <= bad_d;
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_poll_wild;
    poll_req.valid && poll_req.sys_code == CCP_SC_WILD |=> poll_rsp.valid;
  endproperty
  a_poll_wild: assert property (p_poll_wild) else $error("wild poll unanswered");
  property p_poll_cause;
    poll_rsp.valid |-> $past(poll_req.valid);
  endproperty
  a_poll_cause: assert property (p_poll_cause) else $error("answer without poll");
  property p_poll_slot;
    poll_rsp.valid |-> poll_rsp.slot == CCP_SLOT_FIRST;
  endproperty
  a_poll_slot: assert property (p_poll_slot) else $error("answer not in slot 0");
  property p_desc;
    poll_rsp.valid |-> poll_rsp.time_desc[63:24] == {CCP_DESC_FF, CCP_DESC_FF, 24'h0}
      && poll_rsp.time_desc[7:0] == CCP_DESC_FF;
  endproperty
  a_desc: assert property (p_desc) else $error("descriptor fixed bytes wrong");
  property p_done_cause;
    verdict.done |-> $past(cmd_item.valid) && $past(cmd_item.kind) == CCP_K_FINISH;
  endproperty
  a_done_cause: assert property (p_done_cause) else $error("done without finish");
  property p_mem_go;
    verdict.done |-> verdict.mem_go == !verdict.error;
  endproperty
  a_mem_go: assert property (p_mem_go) else $error("memory go against verdict");
  property p_elem_err;
    verdict.done && bad_q |-> verdict.error;
  endproperty
  a_elem_err: assert property (p_elem_err) else $error("bad element passed");
  property p_wr_resp;
    s_axi_awvalid && s_axi_wvalid && s_axi_awready |=> s_axi_bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
endmodule
bind ccp_param_checker ccp_param_checker_assertions i_ccp_param_checker_assertions (
  .core_clk, .rst, .s_axi_awvalid, .s_axi_wvalid, .s_axi_awready, .s_axi_bvalid,
  .poll_req, .poll_rsp, .cmd_item, .verdict);
`default_nettype wire

// ==== verif/ccp_reader_model.sv ====
// reader model driving polls and command items into the frame side
`timescale 1ns/100ps
`default_nettype none
module ccp_reader_model (
  // clock
  input  wire logic              core_clk,
  // requests toward the card
  output ccp_pkg::ccp_poll_req_t poll_req,
  output ccp_pkg::ccp_cmd_item_t cmd_item
);
  import ccp_pkg::*;
  initial begin
    poll_req = '0;
    cmd_item = '0;
  end
  // one poll for one edge; slot count random as it must not matter
  task automatic poll(input logic [15:0] code);
    @(posedge core_clk);
    poll_req <= {1'b1, code, 8'($urandom)};
    @(posedge core_clk);
    poll_req <= {1'b0, 24'($urandom)}; // released fields keep moving
  endtask
  // one item per edge, back to back
  task automatic item(input ccp_kind_t k, input logic w, input logic t3, input logic [23:0] d);
    @(posedge core_clk);
    cmd_item <= {1'b1, k, w, t3, d};
  endtask
  task automatic idle();
    @(posedge core_clk);
    cmd_item <= {1'b0, 28'($urandom)};
  endtask
endmodule
`default_nettype wire

// ==== verif/ccp_param_checker_tb_top.sv ====
// self-checking bench for the card parameter checker
`timescale 1ns/100ps
`default_nettype none
module ccp_param_checker_tb_top;
  import ccp_pkg::*;
  logic core_clk = 1'b0, rst = 1'b1, irq;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  ccp_poll_req_t poll_req;
  ccp_poll_rsp_t poll_rsp;
  ccp_cmd_item_t cmd_item;
  ccp_verdict_t  verdict;
  int errors = 0, checks_done = 0;
  logic [15:0] sc, tm, code;
  logic [63:0] cid;
  logic m;
  logic [2:0] modes [6] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h6, 3'h7};
  always #5 core_clk = ~core_clk;
  ccp_param_checker i_ccp_param_checker (.core_clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .poll_req, .poll_rsp, .cmd_item, .verdict, .irq);
  ccp_reader_model i_ccp_reader_model (.core_clk, .poll_req, .cmd_item);
  task automatic report_and_stop();
    $display("errors=%0d checks_done=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  // a wait that ran out ends the run
  task automatic tmo(input int n);
    if (n >= 64) begin
      errors++;
      report_and_stop();
    end
  endtask
  // one axi4-lite access; request held until its ready edge
  task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_araddr <= a;
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_arvalid <= !wr;
    #1;
    for (n = 0; n < 64 && !(wr ? s_axi_awready && s_axi_wready : s_axi_arready); n++)
      @(posedge core_clk) #1;
    tmo(n);
    @(posedge core_clk);
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= 3'h0;
    s_axi_bready <= wr;
    s_axi_rready <= !wr;
    #1;
    for (n = 0; n < 64 && !(wr ? s_axi_bvalid : s_axi_rvalid); n++) @(posedge core_clk) #1;
    tmo(n);
    q = s_axi_rdata;
    r = wr ? s_axi_bresp : s_axi_rresp;
    @(posedge core_clk);
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [31:0] q;
    logic [1:0] r;
    axi(1'b1, a, d, q, r);
    chk(r, er);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] q;
    logic [1:0] r;
    axi(1'b0, a, 32'h0, q, r);
    chk(q, e);
    chk(r, er);
  endtask
  // timing byte fields e, b, a give the wait in t units
  function automatic logic [19:0] exp_wait(input logic [7:0] p, input int n);
    return 20'(((int'(p[5:3]) + 1) * n + int'(p[2:0]) + 1) << (2 * p[7:6]));
  endfunction
  // f: 0 good, 1 service differs, 2 access bits, 3 mode 101, 4 d2 high, 5 length, 6 modes
  task automatic cmd(input logic w, input int n, input int f, input logic [2:0] md);
    logic [15:0] s;
    logic [7:0] d0, d2;
    logic t3, lst, er;
    s = 16'($urandom);
    i_ccp_reader_model.item(CCP_K_START, w, 1'b0, 24'h0);
    i_ccp_reader_model.item(CCP_K_SERVICE, w, 1'b0, {8'h00, s});
    i_ccp_reader_model.item(CCP_K_SERVICE, w, 1'b0, {8'h00, s ^ 16'(f == 1)});
    for (int i = 0; i < n; i++) begin
      lst = (i == n - 1);
      t3 = (f == 6) || (lst && (f == 3 || f == 4));
      d0 = {!t3, 2'h0, lst && f == 2, 4'($urandom)};
      d2 = t3 ? {lst && f == 4, 4'h0, lst && f == 3 ? CCP_MODE_RSVD : md} : 8'($urandom);
      i_ccp_reader_model.item(CCP_K_ELEMENT, w, t3 ^ (lst && f == 5), {d0, 8'($urandom), d2});
    end
    i_ccp_reader_model.item(CCP_K_FINISH, w, 1'b0, 24'h0);
    i_ccp_reader_model.idle();
    #1;
    er = (f >= 1 && f <= 5);
    chk(verdict.done, 1'b1);
    chk(verdict.error, er);
    chk(verdict.mem_go, !er);
    chk(verdict.blocks, n);
    if (!er) chk(verdict.mode, f == 6 ? md : 3'h0);
    if (!er) chk(verdict.wait_t, exp_wait(w ? tm[15:8] : tm[7:0], n));
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(46));
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    rd(CCP_SYSCODE_OFS, 32'h0, 2'b00);
    rd(CCP_TIMING_OFS, 32'h0, 2'b00);
    rd(CCP_IRQ_MASK_OFS, 32'h0, 2'b00);
    rd(8'h40, 32'h0, 2'b10);
    wr(8'h40, 32'h1, 2'b10);
    cid = {$urandom, $urandom};
    tm = 16'($urandom);
    wr(CCP_ID_LO_OFS, cid[31:0], 2'b00);
    wr(CCP_ID_HI_OFS, cid[63:32], 2'b00);
    wr(CCP_TIMING_OFS, {16'h0, tm}, 2'b00);
    // polls: wild, group, exact and miss, stored upper byte plain then group
    for (int i = 0; i < 16; i++) begin
      sc = i[2] ? {CCP_SC_HI_GROUP, 8'($urandom)} : 16'($urandom);
      code = i % 4 == 0 ? CCP_SC_WILD : i % 4 == 1 ? CCP_SC_GROUP : i % 4 == 2 ? sc : sc ^ 16'h8;
      wr(CCP_SYSCODE_OFS, {16'h0, sc}, 2'b00);
      i_ccp_reader_model.poll(code);
      #1;
      m = code == CCP_SC_WILD || (code == CCP_SC_GROUP && sc[15:8] == CCP_SC_HI_GROUP) || code == sc;
      chk(poll_rsp.valid, m);
      if (m) chk(poll_rsp.card_id, cid);
      if (m) chk(poll_rsp.time_desc, {16'hFFFF, 24'h0, tm[7:0], tm[15:8], 8'hFF});
    end
    // byte strobe: only the upper byte of the stored code may change
    s_axi_wstrb <= 4'h2;
    wr(CCP_SYSCODE_OFS, 32'h0000_5A00, 2'b00);
    s_axi_wstrb <= 4'hF;
    rd(CCP_SYSCODE_OFS, {16'h0, 8'h5A, sc[7:0]}, 2'b00);
    for (int f = 0; f < 6; f++) cmd(f[0], f == 0 ? 15 : 1 + $urandom % 11, f, 3'h0);
    foreach (modes[k]) cmd(k[0], 11, 6, modes[k]);
    // read-only wait word ignores writes and holds the last write command's wait
    wr(CCP_WAIT_OFS, 32'h1, 2'b00);
    rd(CCP_WAIT_OFS, {12'h000, exp_wait(tm[15:8], 11)}, 2'b00);
    rd(CCP_ID_HI_OFS, cid[63:32], 2'b00);
    // poll answered, good and bad commands have all been seen by now
    rd(CCP_IRQ_STAT_OFS, 32'h7, 2'b00);
    // interrupt: unmasked error, clear by one, then masked
    wr(CCP_IRQ_MASK_OFS, 32'h1 << CCP_IRQ_ERR, 2'b00);
    wr(CCP_IRQ_STAT_OFS, 32'h7, 2'b00);
    chk(irq, 1'b0);
    cmd(1'b0, 2, 2, 3'h0);
    chk(irq, 1'b1);
    rd(CCP_IRQ_STAT_OFS, 32'h1 << CCP_IRQ_ERR, 2'b00);
    wr(CCP_IRQ_STAT_OFS, 32'h1 << CCP_IRQ_ERR, 2'b00);
    chk(irq, 1'b0);
    wr(CCP_IRQ_MASK_OFS, 32'h0, 2'b00);
    cmd(1'b1, 1, 5, 3'h0);
    chk(irq, 1'b0);
    report_and_stop();
  end
endmodule
`default_nettype wire
